//--- csr_bank.sv
module csr_bank (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic cal_run,
	input wire logic single_mode,
	output csr_pkg::csr_cfg_s cfg,
	output logic [csr_pkg::CSR_LANES-1:0][2:0] lane_emph_level,
	output logic [csr_pkg::CSR_LANES-1:0] lane_emph_extra,
	output csr_pkg::csr_route_s route
);
	import csr_pkg::*;

	logic ack_q;
	logic [31:0] rdata_q;
	logic [1:0] resp_q;
	logic [15:0] range_b_q;
	logic [7:0] ref_q;
	logic [7:0] stamp_q;
	logic [7:0] emph_q;
	logic [7:0] mux_q;

	// The bus address is the register offset itself, so no register answers at a second address.
	wire hit_range = (avs_address == CSR_OFF_RANGE_B);
	wire hit_ref = (avs_address == CSR_OFF_REF_SRC);
	wire hit_stamp = (avs_address == CSR_OFF_STAMP);
	wire hit_emph = (avs_address == CSR_OFF_EMPH);
	wire hit_mux = (avs_address == CSR_OFF_MUX);
	wire hit_any = hit_range || hit_ref || hit_stamp || hit_emph || hit_mux;
	wire req = (avs_read || avs_write) && !ack_q;
	// A write lands at the edge where the master sees waitrequest low.
	wire wr = avs_write && ack_q;
	wire [15:0] range_wdata = {avs_byteenable[1] ? avs_writedata[15:8] : range_b_q[15:8],
		avs_byteenable[0] ? avs_writedata[7:0] : range_b_q[7:0]};
	wire [7:0] byte_wdata = avs_writedata[7:0];
	wire byte_we = wr && avs_byteenable[0];
	wire [31:0] rd_mux = hit_range ? {16'h0000, range_b_q} :
		hit_ref ? {24'h000000, ref_q} :
		hit_stamp ? {24'h000000, stamp_q} :
		hit_emph ? {24'h000000, emph_q} :
		hit_mux ? {24'h000000, mux_q} : 32'h00000000;

	// One wait cycle per access: waitrequest drops in the cycle after the request is seen.
	// A low clock enable keeps it high, so no access completes while state is frozen.
	assign avs_waitrequest = (avs_read || avs_write) && !(ack_q && ce);

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
			resp_q <= 2'h0;
		end
		else if (ce)
		begin
			ack_q <= req;
			if (req)
			begin
				rdata_q <= avs_read ? rd_mux : 32'h00000000;
				resp_q <= hit_any ? 2'h0 : 2'h3;
			end
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_response = resp_q;

	csr_reg #(.W(16), .RST(CSR_RST_RANGE_B)) u_range (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.we(wr && hit_range && (avs_byteenable[1:0] != 2'h0)),
		.wdata(range_wdata),
		.q(range_b_q)
	);

	csr_reg #(.W(8), .RST(CSR_RST_REF_SRC)) u_ref (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.we(byte_we && hit_ref),
		.wdata(byte_wdata),
		.q(ref_q)
	);

	csr_reg #(.W(8), .RST(CSR_RST_STAMP)) u_stamp (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.we(byte_we && hit_stamp),
		.wdata(byte_wdata),
		.q(stamp_q)
	);

	csr_reg #(.W(8), .RST(CSR_RST_EMPH)) u_emph (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.we(byte_we && hit_emph),
		.wdata(byte_wdata),
		.q(emph_q)
	);

	csr_reg #(.W(8), .RST(CSR_RST_MUX)) u_mux (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.we(byte_we && hit_mux),
		.wdata(byte_wdata),
		.q(mux_q)
	);

	// The range code goes to the analog scaler unchanged; the scaler maps it linearly.
	assign cfg.range_b = range_b_q;
	assign cfg.ref_from_supply = ref_q[CSR_POS_REF_SUPPLY];
	assign cfg.stamp_on = stamp_q[CSR_POS_STAMP_ON];
	assign cfg.stamp_pecl = stamp_q[CSR_POS_STAMP_PECL];
	assign cfg.emph_level = emph_q[CSR_POS_EMPH_LVL +: 3];
	assign cfg.emph_extra = emph_q[CSR_POS_EMPH_EXTRA];

	genvar ln;
	generate
		for (ln = 0; ln < CSR_LANES; ln++)
		begin : g_lane
			assign lane_emph_level[ln] = emph_q[CSR_POS_EMPH_LVL +: 3];
			assign lane_emph_extra[ln] = emph_q[CSR_POS_EMPH_EXTRA];
		end
	endgenerate

	csr_route u_route (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.cal_run(cal_run),
		.single_mode(single_mode),
		.mux_reg(mux_q),
		.route(route)
	);
endmodule

//--- csr_pkg.sv
package csr_pkg;
	localparam logic [7:0] CSR_OFF_RANGE_B = 8'h32;
	localparam logic [7:0] CSR_OFF_REF_SRC = 8'h38;
	localparam logic [7:0] CSR_OFF_STAMP = 8'h3b;
	localparam logic [7:0] CSR_OFF_EMPH = 8'h48;
	localparam logic [7:0] CSR_OFF_MUX = 8'h60;
	localparam logic [15:0] CSR_RST_RANGE_B = 16'ha000;
	localparam logic [7:0] CSR_RST_REF_SRC = 8'h00;
	localparam logic [7:0] CSR_RST_STAMP = 8'h00;
	localparam logic [7:0] CSR_RST_EMPH = 8'h00;
	localparam logic [7:0] CSR_RST_MUX = 8'h01;
	localparam int CSR_POS_REF_SUPPLY = 0;
	localparam int CSR_POS_STAMP_ON = 0;
	localparam int CSR_POS_STAMP_PECL = 1;
	localparam int CSR_POS_EMPH_LVL = 0;
	localparam int CSR_POS_EMPH_EXTRA = 3;
	localparam int CSR_POS_MUX_SINGLE = 0;
	localparam int CSR_POS_MUX_SWAP = 4;
	localparam int CSR_LANES = 16;
	localparam logic [1:0] CSR_SEL_A = 2'h1;
	localparam logic [1:0] CSR_SEL_B = 2'h2;
	localparam logic [1:0] CSR_SEL_BOTH = 2'h3;

	typedef struct packed
	{
		logic [15:0] range_b;
		logic ref_from_supply;
		logic stamp_on;
		logic stamp_pecl;
		logic [2:0] emph_level;
		logic emph_extra;
	} csr_cfg_s;

	typedef struct packed
	{
		logic chan_a_on;
		logic chan_a_from_b;
		logic chan_b_on;
		logic chan_b_from_a;
	} csr_route_s;
endpackage

//--- csr_reg.sv
module csr_reg #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic we,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] q
);
	// Every bit, reserved ones included, stores what software wrote.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			q <= RST;
		else if (ce && we)
			q <= wdata;
	end
endmodule

//--- csr_route.sv
module csr_route (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic cal_run,
	input wire logic single_mode,
	input wire logic [7:0] mux_reg,
	output csr_pkg::csr_route_s route
);
	import csr_pkg::*;

	logic cal_run_q;
	wire cal_start = cal_run && !cal_run_q;
	wire [1:0] sel = mux_reg[CSR_POS_MUX_SINGLE +: 2];
	wire swap = mux_reg[CSR_POS_MUX_SWAP];
	csr_route_s live;

	// Single mode reads only the select field; dual modes only the swap bit.
	always_comb
	begin
		live = '0;
		if (single_mode)
		begin
			live.chan_a_on = (sel == CSR_SEL_A) || (sel == CSR_SEL_B) || (sel == CSR_SEL_BOTH);
			live.chan_a_from_b = (sel == CSR_SEL_B);
			live.chan_b_on = (sel == CSR_SEL_BOTH);
		end
		else
		begin
			live.chan_a_on = 1'b1;
			live.chan_b_on = 1'b1;
			live.chan_a_from_b = swap;
			live.chan_b_from_a = swap;
		end
	end

	// Routing is latched at the rising edge of calibration enable.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			cal_run_q <= 1'b0;
			route <= '0;
		end
		else if (ce)
		begin
			cal_run_q <= cal_run;
			if (cal_start)
				route <= live;
		end
	end
endmodule

//--- csr_bank_checker.sv
module csr_bank_checker (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic cal_run,
	input wire logic single_mode,
	input wire csr_pkg::csr_cfg_s cfg,
	input wire logic [csr_pkg::CSR_LANES-1:0][2:0] lane_emph_level,
	input wire logic [csr_pkg::CSR_LANES-1:0] lane_emph_extra,
	input wire csr_pkg::csr_route_s route
);
	import csr_pkg::*;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_one_wait: assert property ($rose(avs_read | avs_write) && ce |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait state");
	a_lane_level: assert property (lane_emph_level == {16{cfg.emph_level}})
		else $error("lane emphasis level differs from register");
	a_lane_extra: assert property (lane_emph_extra == {16{cfg.emph_extra}})
		else $error("lane emphasis extra differs from register");
	a_route_hold: assert property (!$rose(cal_run) |=> $stable(route))
		else $error("routing changed without calibration");
	a_route_dual: assert property ($rose(cal_run) && !single_mode |=> route.chan_a_on && route.chan_b_on
		&& route.chan_a_from_b == route.chan_b_from_a) else $error("dual routing wrong");
	a_single_noswap: assert property ($rose(cal_run) && single_mode |=> !route.chan_b_from_a)
		else $error("swap applied in single mode");
	a_cfg_hold: assert property (!avs_write |=> $stable(cfg))
		else $error("configuration changed without a write");
	a_cfg_reset: assert property ($fell(reset) |-> cfg == {CSR_RST_RANGE_B, 7'h00})
		else $error("configuration reset value wrong");
	cover property ($rose(cal_run) && single_mode);
	cover property ($rose(cal_run) && !single_mode);
	cover property (avs_write && !avs_waitrequest);
endmodule

bind csr_bank csr_bank_checker i_chk (.*);

//--- tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csr_pkg::*;
	logic mclk = 0, reset = 1, ce = 1, avs_read = 0, avs_write = 0, cal_run = 0, single_mode = 0;
	logic [7:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata;
	logic [3:0] avs_byteenable = 4'hf;
	logic avs_waitrequest;
	logic [1:0] avs_response;
	csr_cfg_s cfg;
	csr_route_s route;
	logic [CSR_LANES-1:0][2:0] lane_emph_level;
	logic [CSR_LANES-1:0] lane_emph_extra;
	logic [33:0] exp_q[$];
	logic [33:0] note;
	logic [31:0] wv [5];
	logic [7:0] adr [5] = '{CSR_OFF_RANGE_B, CSR_OFF_REF_SRC, CSR_OFF_STAMP, CSR_OFF_EMPH, CSR_OFF_MUX};
	logic [31:0] rst_v [5] = '{32'ha000, 32'h0, 32'h0, 32'h0, 32'h1};
	integer num_errors = 0, n_checks = 0, cyc = 0, seed = 32'hde38adcf, i;
	always #5 mclk = ~mclk;
	csr_bank i_dut (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, e});
		bus(0, a, 0);
	endtask
	task automatic cal(input logic s, input logic [7:0] m, input logic [3:0] e);
		bus(1, CSR_OFF_MUX, {24'h0, m});
		single_mode <= s;
		@(posedge mclk);
		cal_run <= 1'b1;
		repeat (2) @(posedge mclk);
		cal_run <= 1'b0;
		@(posedge mclk);
		check({28'h0, route}, {28'h0, e});
	endtask
	task automatic close_out;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
		begin
			if (exp_q.size() == 0)
				num_errors++;
			else
			begin
				note = exp_q.pop_front();
				check(avs_readdata, note[31:0]);
				check({30'h0, avs_response}, {30'h0, note[33:32]});
			end
		end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			close_out;
		end
	end
	initial
	begin
		repeat (2) @(posedge mclk);
		reset <= 0;
		@(posedge mclk);
		for (i = 0; i < 5; i++)
			rd(adr[i], rst_v[i]);
		rd(8'h04, 32'h0, 2'h3);
		ce <= 1'b0;
		avs_address <= CSR_OFF_EMPH;
		avs_writedata <= 32'h7;
		avs_write <= 1'b1;
		repeat (3) @(posedge mclk);
		check({avs_waitrequest, 28'h0, cfg.emph_level}, 32'h80000000);
		ce <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge mclk);
		check({29'h0, cfg.emph_level}, 32'h7);
		$display("reset test done");
		for (i = 0; i < 5; i++)
		begin
			wv[i] = $random(seed) & ((i == 0) ? 32'hffff : 32'hff);
			if (i == 0 && wv[0] < 32'h2000)
				wv[0] = wv[0] | 32'h2000;
			bus(1, adr[i], wv[i]);
			rd(adr[i], wv[i]);
		end
		check({9'h0, cfg},
			{9'h0, wv[0][15:0], wv[1][0], wv[2][0], wv[2][1], wv[3][2:0], wv[3][3]});
		check({24'h0, lane_emph_extra[15], lane_emph_level[15], lane_emph_extra[0], lane_emph_level[0]},
			{24'h0, wv[3][3:0], wv[3][3:0]});
		bus(1, CSR_OFF_RANGE_B, 32'h2000);
		check({16'h0, cfg.range_b}, 32'h2000);
		bus(1, CSR_OFF_RANGE_B, 32'hffff);
		check({16'h0, cfg.range_b}, 32'hffff);
		avs_byteenable <= 4'h2;
		bus(1, CSR_OFF_RANGE_B, 32'h5a5a);
		avs_byteenable <= 4'he;
		bus(1, CSR_OFF_EMPH, {24'h0, ~wv[3][7:0]});
		avs_byteenable <= 4'hf;
		check({16'h0, cfg.range_b}, 32'h5aff);
		check({29'h0, cfg.emph_level}, {29'h0, wv[3][2:0]});
		$display("write test done");
		cal(1, 8'h11, 4'b1000);
		cal(1, 8'h02, 4'b1100);
		cal(1, 8'h13, 4'b1010);
		cal(1, 8'h10, 4'b0000);
		cal(0, 8'h00, 4'b1010);
		cal(0, 8'h12, 4'b1111);
		bus(1, CSR_OFF_MUX, 32'h01);
		check({28'h0, route}, 32'hf);
		$display("route test done");
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		check({28'h0, route}, 32'h0);
		for (i = 0; i < 5; i++)
			rd(adr[i], rst_v[i]);
		$display("second reset test done");
		close_out;
	end
endmodule
